/* File: inc/clock_mode_params.svh */
/*
 * Constants of the system clock and operating mode controller: register
 * offsets, field positions, reset values and stabilisation counts.
 * Assumes it is included by bare name from the design file.
 */
`ifndef CLOCK_MODE_PARAMS_SVH
`define CLOCK_MODE_PARAMS_SVH

// Register offsets on the plain register port
`define OFF_SYS_CLOCK_CONTROL 2'h0
`define OFF_CRYSTAL_CONTROL 2'h1
`define OFF_FAST_RC_CONTROL 2'h2

// System clock control field positions
`define SCC_SEL_MSB 7
`define SCC_SEL_LSB 5
`define SCC_HIGH_SRC 3
`define SCC_HIGH_KEEP 1
`define SCC_LOW_KEEP 0

// Oscillator control field positions
`define OSC_ENABLE_BIT 0
`define OSC_STABLE_BIT 1

// Reset values and the slow select code
`define SEL_RESET 3'h2
`define SEL_SLOW 3'h7
`define CRYSTAL_EN_RESET 1'h0
`define FAST_RC_EN_RESET 1'h1

// Counts in slow RC periods
`define CRYSTAL_STABLE_TICKS 8'h20
`define FAST_RC_STABLE_TICKS 8'h04
`define SLOW_RC_STABLE_TICKS 8'h02
`define MISSING_CLOCK_TICKS 8'h08

`endif

/* File: inc/clock_mode_pkg.sv */
/*
 * Types of the system clock and operating mode controller.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package clock_mode_pkg;

  // Operating modes
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b000,
    MODE_SLOW = 3'b001,
    MODE_SLEEP = 3'b010,
    MODE_IDLE_LOW_ONLY = 3'b011,
    MODE_IDLE_BOTH_CLOCKS = 3'b100,
    MODE_IDLE_HIGH_ONLY = 3'b101
  } op_mode_t;

  // Oscillator run requests to the analog cells
  typedef struct packed {
    logic crystal_oscillator;
    logic fast_rc_oscillator;
    logic slow_rc_oscillator;
  } osc_run_t;

  // Clocks handed to the CPU and peripherals
  typedef struct packed {
    logic sys_clk;
    logic high_clk;
    logic low_clk;
  } clk_out_t;

endpackage : clock_mode_pkg

/* File: hdl/system_clock_mode_control.sv */
/*
 * System clock source selection, divided system clock, operating mode
 * control on halt, oscillator stable flags and missing clock detection.
 * Assumes oscillator outputs arrive asynchronously on pins, halt, wake,
 * watchdog enable and frequency-change requests come from logic on clock.
 */
`include "clock_mode_params.svh"

module system_clock_mode_control
  import clock_mode_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic crystal_osc_in,
  input wire logic fast_rc_osc_in,
  input wire logic slow_rc_osc_in,
  input wire logic halt_req,
  input wire logic wake_req,
  input wire logic watchdog_enable,
  input wire logic fast_rc_freq_change,
  output osc_run_t osc_run,
  output clk_out_t clk_out,
  output logic cpu_run,
  output op_mode_t op_mode,
  output logic mcd_reset
);

  // Divided level for a select code; code 111 is handled by the caller
  function automatic logic div_level(input logic [2:0] code, input logic [5:0] cnt,
                                     input logic lvl);
    case (code)
      3'h0: div_level = lvl;
      3'h1: div_level = cnt[0];
      3'h2: div_level = cnt[1];
      3'h3: div_level = cnt[2];
      3'h4: div_level = cnt[3];
      3'h5: div_level = cnt[4];
      3'h6: div_level = cnt[5];
      default: div_level = 1'b0;
    endcase
  endfunction : div_level

  // Mode entered by a halt from the two keep bits
  function automatic op_mode_t halt_mode(input logic hkeep, input logic lkeep);
    if (hkeep && lkeep) begin
      halt_mode = MODE_IDLE_BOTH_CLOCKS;
    end else if (hkeep) begin
      halt_mode = MODE_IDLE_HIGH_ONLY;
    end else if (lkeep) begin
      halt_mode = MODE_IDLE_LOW_ONLY;
    end else begin
      halt_mode = MODE_SLEEP;
    end
  endfunction : halt_mode

  logic [2:0] sys_clk_select_reg;
  logic high_src_select_reg;
  logic high_osc_idle_keep_reg;
  logic low_osc_idle_keep_reg;
  logic crystal_osc_enable_reg;
  logic fast_rc_osc_enable_reg;
  logic crystal_stable_flag_reg;
  logic fast_rc_stable_flag_reg;
  logic slow_stable_reg;
  logic [2:0] osc_meta_reg;
  logic [2:0] osc_sync_reg;
  logic [2:0] osc_prev_reg;
  logic [5:0] div_cnt_reg;
  logic [2:0] applied_sel_reg;
  logic sys_gate_reg;
  logic [7:0] crystal_cnt_reg;
  logic [7:0] fast_rc_cnt_reg;
  logic [7:0] slow_cnt_reg;
  logic [7:0] mcd_cnt_reg;
  op_mode_t mode_reg;
  logic halted;
  logic crystal_run;
  logic fast_rc_run;
  logic slow_run;
  logic high_lvl;
  logic high_edge;
  logic low_lvl;
  logic slow_tick;
  logic cur_level;
  logic new_level;
  logic gate_next;
  logic crystal_set_write;

  // Pins pass two flip-flops; the second stage and a third, delayed copy for edge detection are looked at
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      osc_meta_reg <= 3'h0;
      osc_sync_reg <= 3'h0;
      osc_prev_reg <= 3'h0;
    end else begin
      osc_meta_reg <= {crystal_osc_in, fast_rc_osc_in, slow_rc_osc_in};
      osc_sync_reg <= osc_meta_reg;
      osc_prev_reg <= osc_sync_reg;
    end
  end

  // Oscillator run requests per mode
  assign halted = (mode_reg != MODE_NORMAL) && (mode_reg != MODE_SLOW);
  assign crystal_run = crystal_osc_enable_reg &&
                       (mode_reg != MODE_SLEEP) && (mode_reg != MODE_IDLE_LOW_ONLY);
  assign fast_rc_run = fast_rc_osc_enable_reg &&
                       (mode_reg != MODE_SLEEP) && (mode_reg != MODE_IDLE_LOW_ONLY);
  assign slow_run = !halted || low_osc_idle_keep_reg || watchdog_enable;

  // High clock from the selected fast source, low clock from slow RC only
  assign high_lvl = high_src_select_reg ? (osc_sync_reg[2] && crystal_run)
                                        : (osc_sync_reg[1] && fast_rc_run);
  assign high_edge = high_src_select_reg ? (osc_sync_reg[2] && !osc_prev_reg[2] && crystal_run)
                                         : (osc_sync_reg[1] && !osc_prev_reg[1] && fast_rc_run);
  assign low_lvl = osc_sync_reg[0] && slow_run;
  assign slow_tick = osc_sync_reg[0] && !osc_prev_reg[0] && slow_run;

  // Mux levels of the applied and the requested selection
  assign cur_level = (applied_sel_reg == `SEL_SLOW) ? low_lvl
                   : div_level(applied_sel_reg, div_cnt_reg, high_lvl);
  assign new_level = (sys_clk_select_reg == `SEL_SLOW) ? low_lvl
                   : div_level(sys_clk_select_reg, div_cnt_reg, high_lvl);

  // System clock on or off per mode
  always_comb begin
    case (mode_reg)
      MODE_NORMAL: gate_next = 1'b1;
      MODE_SLOW: gate_next = 1'b1;
      MODE_SLEEP: gate_next = 1'b0;
      MODE_IDLE_LOW_ONLY: gate_next = (applied_sel_reg == `SEL_SLOW);
      MODE_IDLE_BOTH_CLOCKS: gate_next = 1'b1;
      MODE_IDLE_HIGH_ONLY: gate_next = (applied_sel_reg != `SEL_SLOW);
      default: gate_next = 1'b0;
    endcase
  end

  assign crystal_set_write = reg_wr && (reg_addr == `OFF_CRYSTAL_CONTROL) &&
                             reg_wdata[`OSC_ENABLE_BIT] && !crystal_osc_enable_reg;

  // Register writes
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sys_clk_select_reg <= `SEL_RESET;
      high_src_select_reg <= 1'b0;
      high_osc_idle_keep_reg <= 1'b0;
      low_osc_idle_keep_reg <= 1'b0;
      crystal_osc_enable_reg <= `CRYSTAL_EN_RESET;
      fast_rc_osc_enable_reg <= `FAST_RC_EN_RESET;
    end else if (reg_wr) begin
      if (reg_addr == `OFF_SYS_CLOCK_CONTROL) begin
        sys_clk_select_reg <= reg_wdata[`SCC_SEL_MSB:`SCC_SEL_LSB];
        high_src_select_reg <= reg_wdata[`SCC_HIGH_SRC];
        high_osc_idle_keep_reg <= reg_wdata[`SCC_HIGH_KEEP];
        low_osc_idle_keep_reg <= reg_wdata[`SCC_LOW_KEEP];
      end else if (reg_addr == `OFF_CRYSTAL_CONTROL) begin
        crystal_osc_enable_reg <= reg_wdata[`OSC_ENABLE_BIT];
      end else if (reg_addr == `OFF_FAST_RC_CONTROL) begin
        fast_rc_osc_enable_reg <= reg_wdata[`OSC_ENABLE_BIT];
      end
    end
  end

  // Register reads, data one cycle later; unmapped offset reads zero
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == `OFF_SYS_CLOCK_CONTROL) begin
        reg_rdata <= {sys_clk_select_reg, 1'b0, high_src_select_reg, 1'b0,
                      high_osc_idle_keep_reg, low_osc_idle_keep_reg};
      end else if (reg_addr == `OFF_CRYSTAL_CONTROL) begin
        reg_rdata <= {6'h00, crystal_stable_flag_reg, crystal_osc_enable_reg};
      end else if (reg_addr == `OFF_FAST_RC_CONTROL) begin
        reg_rdata <= {6'h00, fast_rc_stable_flag_reg, fast_rc_osc_enable_reg};
      end else begin
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Operating mode: halt only from a running mode, wake back to run
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mode_reg <= MODE_NORMAL;
    end else if (!halted && halt_req) begin
      mode_reg <= halt_mode(high_osc_idle_keep_reg, low_osc_idle_keep_reg);
    end else if (!halted || wake_req) begin
      mode_reg <= (applied_sel_reg == `SEL_SLOW) ? MODE_SLOW : MODE_NORMAL;
    end
  end

  // High clock divider; free running so a new tap is always in phase
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      div_cnt_reg <= 6'h00;
    end else if (high_edge) begin
      div_cnt_reg <= div_cnt_reg + 6'h01;
    end
  end

  // Glitch-free switch: both old and new clocks low, slow RC stable for 111
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      applied_sel_reg <= `SEL_RESET;
    end else if ((sys_clk_select_reg != applied_sel_reg) && !cur_level && !new_level &&
                 ((sys_clk_select_reg != `SEL_SLOW) || slow_stable_reg)) begin
      applied_sel_reg <= sys_clk_select_reg;
    end
  end

  // Gate only moves while the clock is low, so no pulse is cut short
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sys_gate_reg <= 1'b1;
    end else if (!cur_level) begin
      sys_gate_reg <= gate_next;
    end
  end

  // Slow RC stability counted on its own edges since it was started
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      slow_cnt_reg <= 8'h00;
      slow_stable_reg <= 1'b0;
    end else if (!slow_run) begin
      slow_cnt_reg <= 8'h00;
      slow_stable_reg <= 1'b0;
    end else if (slow_tick && !slow_stable_reg) begin
      slow_cnt_reg <= slow_cnt_reg + 8'h01;
      slow_stable_reg <= (slow_cnt_reg + 8'h01) >= `SLOW_RC_STABLE_TICKS;
    end
  end

  // Crystal stable flag; a fresh enable restarts the count
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      crystal_cnt_reg <= 8'h00;
      crystal_stable_flag_reg <= 1'b0;
    end else if (crystal_set_write || !crystal_run) begin
      crystal_cnt_reg <= 8'h00;
      crystal_stable_flag_reg <= 1'b0;
    end else if (slow_tick && !crystal_stable_flag_reg) begin
      crystal_cnt_reg <= crystal_cnt_reg + 8'h01;
      crystal_stable_flag_reg <= (crystal_cnt_reg + 8'h01) >= `CRYSTAL_STABLE_TICKS;
    end
  end

  // Fast RC stable flag; a frequency change restarts the count
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fast_rc_cnt_reg <= 8'h00;
      fast_rc_stable_flag_reg <= 1'b0;
    end else if ((fast_rc_freq_change && fast_rc_osc_enable_reg) || !fast_rc_run) begin
      fast_rc_cnt_reg <= 8'h00;
      fast_rc_stable_flag_reg <= 1'b0;
    end else if (slow_tick && !fast_rc_stable_flag_reg) begin
      fast_rc_cnt_reg <= fast_rc_cnt_reg + 8'h01;
      fast_rc_stable_flag_reg <= (fast_rc_cnt_reg + 8'h01) >= `FAST_RC_STABLE_TICKS;
    end
  end

  // Missing clock detector on the selected high oscillator while it runs
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mcd_cnt_reg <= 8'h00;
      mcd_reset <= 1'b0;
    end else if (!(high_src_select_reg ? crystal_run : fast_rc_run) || high_edge) begin
      mcd_cnt_reg <= 8'h00;
      mcd_reset <= 1'b0;
    end else if (mcd_cnt_reg >= `MISSING_CLOCK_TICKS) begin
      mcd_cnt_reg <= 8'h00;
      mcd_reset <= 1'b1;
    end else begin
      mcd_cnt_reg <= slow_tick ? mcd_cnt_reg + 8'h01 : mcd_cnt_reg;
      mcd_reset <= 1'b0;
    end
  end

  // Registered outputs
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      clk_out <= '0;
      osc_run <= '0;
      cpu_run <= 1'b0;
      op_mode <= MODE_NORMAL;
    end else begin
      clk_out.sys_clk <= cur_level && sys_gate_reg;
      clk_out.high_clk <= high_lvl;
      clk_out.low_clk <= low_lvl;
      osc_run.crystal_oscillator <= crystal_run;
      osc_run.fast_rc_oscillator <= fast_rc_run;
      osc_run.slow_rc_oscillator <= slow_run;
      cpu_run <= !halted;
      op_mode <= mode_reg;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_halt_running;
    !halted && halt_req;
  endsequence

  a_crystal_read_zero: assert property (
    reg_rd && reg_addr == `OFF_CRYSTAL_CONTROL |=>
      reg_rdata == {6'h00, $past(crystal_stable_flag_reg), $past(crystal_osc_enable_reg)})
    else $error("crystal control read data wrong");
  a_crystal_flag_clear: assert property (
    crystal_set_write |=> !crystal_stable_flag_reg ##1 !crystal_stable_flag_reg)
    else $error("crystal flag not cleared on enable");
  a_sleep_entry: assert property (
    s_halt_running ##0 !high_osc_idle_keep_reg && !low_osc_idle_keep_reg |=>
      mode_reg == MODE_SLEEP ##1 !cpu_run && !osc_run.crystal_oscillator)
    else $error("sleep mode not entered");
  a_idle_low_gate: assert property (
    mode_reg == MODE_IDLE_LOW_ONLY && !cur_level |=>
      sys_gate_reg == ($past(applied_sel_reg) == `SEL_SLOW))
    else $error("idle low-only gate wrong");
  a_idle_both_run: assert property (
    mode_reg == MODE_IDLE_BOTH_CLOCKS && fast_rc_osc_enable_reg && !high_src_select_reg |=>
      osc_run.fast_rc_oscillator && osc_run.slow_rc_oscillator)
    else $error("idle both clocks stopped an oscillator");
  a_slow_rc_watchdog: assert property (
    watchdog_enable || low_osc_idle_keep_reg |=> osc_run.slow_rc_oscillator)
    else $error("slow RC off with watchdog enabled");
  a_slow_wait_stable: assert property (
    $changed(applied_sel_reg) && applied_sel_reg == 3'h7 |-> $past(slow_stable_reg))
    else $error("slow mode applied before slow RC stable");
  a_switch_when_low: assert property (
    $changed(applied_sel_reg) |-> $past(cur_level) == 1'b0 && !clk_out.sys_clk)
    else $error("clock select switched while clock high");
  a_mcd_fires: assert property (
    (high_src_select_reg ? crystal_run : fast_rc_run) && !high_edge &&
      mcd_cnt_reg >= `MISSING_CLOCK_TICKS |=> mcd_reset)
    else $error("missing clock reset not raised");

  // Idle gating, flag restart and read port checks
  a_idle_high_gate: assert property (
    mode_reg == MODE_IDLE_HIGH_ONLY && !cur_level |=>
      sys_gate_reg == ($past(applied_sel_reg) != `SEL_SLOW))
    else $error("idle high-only gate wrong");
  a_fast_flag_clear: assert property (
    fast_rc_freq_change && fast_rc_osc_enable_reg |=> !fast_rc_stable_flag_reg)
    else $error("fast RC flag not cleared on frequency change");
  a_rdata_idle_zero: assert property (
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_sys_read_zero: assert property (
    reg_rd && reg_addr == `OFF_SYS_CLOCK_CONTROL |=> reg_rdata[4] == 1'b0 && reg_rdata[2] == 1'b0)
    else $error("system control unused bits not zero");

endmodule : system_clock_mode_control

/* File: tb/osc_clock_model.sv */
/*
 * Oscillator model at the far side: crystal, fast RC and slow RC cells
 * that run only while the controller asks them to.
 * Assumes the controller's clock and reset; the test may kill the crystal.
 */
module osc_clock_model
  import clock_mode_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire osc_run_t osc_run,
  input wire logic crystal_dead,
  output logic crystal_osc_in,
  output logic fast_rc_osc_in,
  output logic slow_rc_osc_in
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [5:0] cnt;

  // Slow strides only: the controller samples at its own clock, fast waves would alias
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt <= 6'h00;
      crystal_osc_in <= 1'h0;
      fast_rc_osc_in <= 1'h0;
      slow_rc_osc_in <= 1'h0;
    end else begin
      cnt <= cnt + 6'h01;
      // A stopped or broken cell stands still low
      crystal_osc_in <= osc_run.crystal_oscillator & !crystal_dead & cnt[3];
      fast_rc_osc_in <= osc_run.fast_rc_oscillator & cnt[2];
      slow_rc_osc_in <= osc_run.slow_rc_oscillator & cnt[5];
    end
  end
endmodule : osc_clock_model

/* File: tb/system_clock_mode_control_tb.sv */
/*
 * Self-checking bench of the clock and mode controller: register port,
 * stable flags, divided clock, slow mode, halt modes, missing clock.
 * Assumes the oscillator model above and the design's package.
 */
module system_clock_mode_control_tb;
  import clock_mode_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic crystal_osc_in, fast_rc_osc_in, slow_rc_osc_in;
  logic halt_req = 1'b0;
  logic wake_req = 1'b0;
  logic watchdog_enable = 1'b0;
  logic fast_rc_freq_change = 1'b0;
  logic crystal_dead = 1'b0;
  osc_run_t osc_run;
  clk_out_t clk_out;
  logic cpu_run;
  op_mode_t op_mode;
  logic mcd_reset;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  int mcd_seen = 0;
  op_mode_t halt_mode [4] = '{MODE_SLEEP, MODE_IDLE_LOW_ONLY, MODE_IDLE_HIGH_ONLY,
                              MODE_IDLE_BOTH_CLOCKS};

  system_clock_mode_control dut (.clock(clock), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .crystal_osc_in(crystal_osc_in), .fast_rc_osc_in(fast_rc_osc_in),
    .slow_rc_osc_in(slow_rc_osc_in), .halt_req(halt_req), .wake_req(wake_req),
    .watchdog_enable(watchdog_enable), .fast_rc_freq_change(fast_rc_freq_change),
    .osc_run(osc_run), .clk_out(clk_out), .cpu_run(cpu_run), .op_mode(op_mode),
    .mcd_reset(mcd_reset));

  osc_clock_model osc (.clock(clock), .nrst(nrst), .osc_run(osc_run),
    .crystal_dead(crystal_dead), .crystal_osc_in(crystal_osc_in),
    .fast_rc_osc_in(fast_rc_osc_in), .slow_rc_osc_in(slow_rc_osc_in));

  // 20 MHz clock
  always #25 clock = ~clock;

  // Hang guard and reset-request counter
  always @(posedge clock) begin
    cycles++;
    if (mcd_reset === 1'b1) mcd_seen++;
    if (cycles == 40000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  task automatic rdc(input string name, input logic [1:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    check(name, v, exp);
  endtask : rdc

  // Rises of one output clock over n cycles: 2 system, 1 high, 0 low
  task automatic count_rises(input int which, input int n, output int r);
    logic prev;
    logic cur;
    r = 0;
    prev = clk_out[which];
    repeat (n) begin
      @(posedge clock);
      #1 cur = clk_out[which];
      if (cur === 1'b1 && prev === 1'b0) r++;
      prev = cur;
    end
  endtask : count_rises

  // One-cycle pulse: 0 halt, 1 wake, 2 frequency change
  task automatic pulse(input int which);
    @(posedge clock);
    halt_req <= (which == 0);
    wake_req <= (which == 1);
    fast_rc_freq_change <= (which == 2);
    @(posedge clock);
    halt_req <= 1'b0;
    wake_req <= 1'b0;
    fast_rc_freq_change <= 1'b0;
  endtask : pulse

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  // Main sequence
  initial begin
    int r;
    int e;
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    rdc("fast_rc_ctl", 2'h2, 8'h01);
    rdc("crystal_ctl", 2'h1, 8'h00);
    rdc("sys_ctl", 2'h0, 8'h40);
    rdc("unmapped", 2'h3, 8'h00);
    repeat (500) @(posedge clock);
    rdc("fast_rc_ctl", 2'h2, 8'h03);
    // Reserved bits and the read-only flag ignore writes
    wr(2'h0, 8'h1F);
    wr(2'h1, 8'hFE);
    wr(2'h3, 8'hFF);
    rdc("sys_ctl", 2'h0, 8'h0B);
    rdc("crystal_ctl", 2'h1, 8'h00);
    // Crystal start-up: flag low, then high once stable
    wr(2'h1, 8'h01);
    rdc("crystal_ctl", 2'h1, 8'h01);
    repeat (2600) @(posedge clock);
    rdc("crystal_ctl", 2'h1, 8'h03);
    pulse(2);
    rdc("fast_rc_ctl", 2'h2, 8'h01);
    repeat (500) @(posedge clock);
    rdc("fast_rc_ctl", 2'h2, 8'h03);
    // Divided system clock from the fast RC, a rise per 8 cycles undivided
    for (int s = 0; s < 7; s++) begin
      wr(2'h0, {s[2:0], 5'h00});
      repeat (600) @(posedge clock);
      count_rises(2, 2048, r);
      e = 256 >> s;
      check("sys_clk_rises", {7'h00, r >= e - 2 && r <= e + 2}, 8'h01);
    end
    wr(2'h0, 8'hE0);
    repeat (400) @(posedge clock);
    check("slow_mode", {5'h00, op_mode}, {5'h00, MODE_SLOW});
    check("slow_cpu", {7'h00, cpu_run}, 8'h01);
    check("slow_fast_run", {7'h00, osc_run.fast_rc_oscillator}, 8'h01);
    wr(2'h0, 8'h00);
    repeat (400) @(posedge clock);
    check("normal_mode", {5'h00, op_mode}, {5'h00, MODE_NORMAL});
    // Halt with every pair of keep bits; watchdog on only for sleep
    for (int k = 0; k < 4; k++) begin
      watchdog_enable <= (k == 0);
      wr(2'h0, {6'h00, k[1:0]});
      pulse(0);
      repeat (4) @(posedge clock);
      check("halt_mode", {5'h00, op_mode}, {5'h00, halt_mode[k]});
      check("halt_cpu", {7'h00, cpu_run}, 8'h00);
      check("halt_fast", {7'h00, osc_run.fast_rc_oscillator}, {7'h00, k[1]});
      check("halt_slow", {7'h00, osc_run.slow_rc_oscillator}, {7'h00, k[0] | (k == 0)});
      count_rises(2, 130, r);
      check("halt_sys_clk", {7'h00, r > 0}, {7'h00, k[1]});
      count_rises(1, 130, r);
      check("halt_high_clk", {7'h00, r > 0}, {7'h00, k[1]});
      count_rises(0, 130, r);
      check("halt_low_clk", {7'h00, r > 0}, {7'h00, k[0] | (k == 0)});
      pulse(1);
      repeat (4) @(posedge clock);
      check("wake_cpu", {7'h00, cpu_run}, 8'h01);
    end
    watchdog_enable <= 1'b0;
    // Crystal selected, then stalled: detector must request a reset
    wr(2'h0, 8'h08);
    repeat (552) @(posedge clock);
    check("crystal_run", {7'h00, osc_run.crystal_oscillator}, 8'h01);
    // Crystal model toggles every 8 cycles: 128 rises undivided
    count_rises(2, 2048, r);
    check("crystal_sys_clk", {7'h00, r >= 126 && r <= 130}, 8'h01);
    check("mcd_quiet", mcd_seen[7:0], 8'h00);
    @(posedge clock);
    crystal_dead <= 1'b1;
    repeat (1200) @(posedge clock);
    check("mcd_fired", {7'h00, mcd_seen > 0}, 8'h01);
    tally_and_finish();
  end
endmodule : system_clock_mode_control_tb
